// file: src/apms_pkg.sv
// constants, field positions and mode type of the power mode sequencer
// assumes a single 25 MHz clock for every user of this package
package apms_pkg;

	localparam int CLK_HZ         = 25_000_000;
	localparam int CLK_NS         = 40;
	localparam int FSW_S0_HZ      = 250_000;
	localparam int BLANK_NS       = 400;
	localparam int DUTY_S3_PCT    = 90;
	localparam int PCT_FULL       = 100;
	localparam int CNT_W          = 7;

	localparam logic [CNT_W-1:0] PERIOD_S0 = CNT_W'(CLK_HZ / FSW_S0_HZ);
	localparam logic [CNT_W-1:0] PERIOD_S3 =
		CNT_W'(CLK_HZ / (2 * FSW_S0_HZ));
	localparam logic [CNT_W-1:0] DUTY_MAX_S3 =
		CNT_W'(CLK_HZ / (2 * FSW_S0_HZ) * DUTY_S3_PCT / PCT_FULL);
	localparam logic [CNT_W-1:0] BLANK_CYC =
		CNT_W'((BLANK_NS + CLK_NS - 1) / CLK_NS);
	// the synced compare is two edges older than the gate pin it
	// qualifies, so arming waits that much past the blanking count
	localparam logic [CNT_W-1:0] SENSE_LAG = 7'h02;
	localparam logic [CNT_W-1:0] BLANK_ARM = BLANK_CYC + SENSE_LAG;
	localparam logic [CNT_W-1:0] CNT_ONE   = 7'h01;

	// positions in the synchronised input vector
	localparam int SYNC_W         = 9;
	localparam int IX_SLEEP       = 0;
	localparam int IX_STANDBY     = 1;
	localparam int IX_GATE        = 2;
	localparam int IX_AUX         = 3;
	localparam int IX_REF         = 4;
	localparam int IX_SS_DONE     = 5;
	localparam int IX_RAIL_OK     = 6;
	localparam int IX_OC_CMP      = 7;
	localparam int IX_SS_GND      = 8;

	typedef enum logic [1:0] {APMS_S5, APMS_S0, APMS_S3} apms_mode_t;

endpackage

// file: src/apms_pwm_if.sv
// carrier between the mode sequencer and its pwm generator
// assumes both ends share clk
`timescale 1ns/1ps
interface apms_pwm_if;
	import apms_pkg::*;
	logic             run;
	logic             fast;
	logic [CNT_W-1:0] duty;
	logic             high_side;
	logic             blank_done;
	modport ctrl (output run, fast, duty, input high_side, blank_done);
	modport gen (input run, fast, duty, output high_side, blank_done);
endinterface

// file: src/apms_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
// assumes inputs are quasi-static levels, not pulses
`timescale 1ns/1ps
module apms_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,  // system clock
	input  wire logic         rst,  // async reset, high
	input  wire logic [W-1:0] d,    // asynchronous levels
	output logic      [W-1:0] q     // synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} apms_sync_st_t;

	apms_sync_st_t st;
	apms_sync_st_t next_st;

	always_comb
	begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.s2;
endmodule // apms_sync

// file: src/apms_pwm.sv
// fixed-frequency pwm counter with high-side blanking timer
// assumes duty arrives in S0 clock cycles, 0 to PERIOD_S0
`timescale 1ns/1ps
module apms_pwm (
	input  wire logic clk,    // system clock
	input  wire logic rst,    // async reset, high
	apms_pwm_if.gen   p       // control and gate status
);
	import apms_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] blank;
		logic             hs;
	} apms_pwm_st_t;

	apms_pwm_st_t     st;
	apms_pwm_st_t     next_st;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] duty;

	always_comb
	begin
		next_st = st;
		period = p.fast ? PERIOD_S3 : PERIOD_S0;
		duty = p.duty;
		if (p.fast)
		begin
			duty = p.duty >> 1;
			if (duty > DUTY_MAX_S3)
				duty = DUTY_MAX_S3;
		end
		if (!p.run)
			next_st = '0;
		else
		begin
			next_st.cnt = (st.cnt >= period - CNT_ONE) ? '0 : st.cnt + CNT_ONE;
			next_st.hs = next_st.cnt < duty;
			// saturate so a 100 percent duty keeps the compare armed
			if (next_st.hs && st.hs)
				next_st.blank = (st.blank >= BLANK_ARM) ? BLANK_ARM
					: st.blank + CNT_ONE;
			else
				next_st.blank = '0;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign p.high_side  = st.hs;
	assign p.blank_done = st.hs && (st.blank >= BLANK_ARM);

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_blank_wait: assert property ($rose(st.hs) |-> (!p.blank_done) [*8])
		else $error("overcurrent compare armed inside blanking");
	a_s3_duty_cap: assert property (
		(p.run && p.fast && $past(p.fast) && st.cnt >= DUTY_MAX_S3)
		|-> !st.hs)
		else $error("standby duty above limit");
endmodule // apms_pwm

// file: src/apms_seq.sv
// acpi power mode sequencer: S5/S0/S3 tracking, regulator enables,
// main switcher gate drive and overcurrent latch-off in S0
// assumes analog status levels arrive asynchronously on pins and
// that the supply detectors are only meaningful once enabled here
`timescale 1ns/1ps
module apms_seq (
	input  wire logic               clk,                  // 25 MHz clock
	input  wire logic               rst,                  // async reset
	input  wire logic               sleep_request,        // high asks S3
	input  wire logic               standby_supply_good,  // detector
	input  wire logic               gate_supply_good,     // detector
	input  wire logic               aux_supply_good,      // detector
	input  wire logic               reference_good,       // bandgap ok
	input  wire logic               soft_start_done,      // ramp finished
	input  wire logic               main_rail_regulating, // fb in window
	input  wire logic               switch_below_sense,   // oc comparator
	input  wire logic               soft_start_grounded,  // ss pin at 0
	input  wire logic [apms_pkg::CNT_W-1:0] duty_cmd,     // S0 on cycles
	output logic [1:0]              mode,                 // 0 S5 1 S0 2 S3
	output logic                    standby_monitor_en,   // detector en
	output logic                    supply_monitor_en,    // gate/aux en
	output logic                    soft_start_en,        // main ramp en
	output logic                    main_rail_in_regulation, // rail ok
	output logic                    termination_en,       // term reg on
	output logic                    termination_oe_n,     // low drives
	output logic                    linear_oe_n,          // low drives
	output logic                    first_linear_drive,   // linear 1 on
	output logic                    second_linear_drive,  // linear 2 on
	output logic                    high_side_gate,       // main top fet
	output logic                    low_side_gate,        // main bot fet
	output logic                    overcurrent_latched   // latch state
);
	import apms_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		apms_mode_t mode;
		logic       sleep_prev;
		logic [2:0] good_prev;
		logic       oc;
		logic       std_mon;
		logic       sup_mon;
		logic       ss_en;
		logic       in_reg;
		logic       hs;
		logic       ls;
	} apms_seq_st_t;

	apms_seq_st_t        st;
	apms_seq_st_t        next_st;
	logic [SYNC_W-1:0]   raw;
	logic [SYNC_W-1:0]   syn;
	logic                sleep;
	logic                ref_ok;
	logic [2:0]          goods;
	logic                all_good;
	logic                rise;
	logic                fall;
	logic                oc_trip;
	logic                supply_lost;
	logic                run;

	apms_pwm_if pwm ();

	////////////////////////////////////////////////////////////////////////
	// input synchronisers and pwm generator

	assign raw[IX_SLEEP]   = sleep_request;
	assign raw[IX_STANDBY] = standby_supply_good;
	assign raw[IX_GATE]    = gate_supply_good;
	assign raw[IX_AUX]     = aux_supply_good;
	assign raw[IX_REF]     = reference_good;
	assign raw[IX_SS_DONE] = soft_start_done;
	assign raw[IX_RAIL_OK] = main_rail_regulating;
	assign raw[IX_OC_CMP]  = switch_below_sense;
	assign raw[IX_SS_GND]  = soft_start_grounded;

	apms_sync #(
		.W   (SYNC_W)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (raw),
		.q   (syn)
	);

	apms_pwm u_pwm (
		.clk (clk),
		.rst (rst),
		.p   (pwm)
	);

	// pwm follows the registered mode, so it never runs in S5
	assign pwm.run  = (st.mode != APMS_S5) && !st.oc;
	assign pwm.fast = (st.mode == APMS_S3);
	assign pwm.duty = duty_cmd;

	////////////////////////////////////////////////////////////////////////
	// decoded conditions

	assign sleep    = syn[IX_SLEEP];
	assign ref_ok   = syn[IX_REF];
	// detectors are gated by their enables; a disabled one reads bad
	assign goods    = {syn[IX_STANDBY] & st.std_mon,
		syn[IX_GATE] & st.sup_mon, syn[IX_AUX] & st.sup_mon};
	assign all_good = &goods;
	assign rise     = sleep && !st.sleep_prev;
	assign fall     = !sleep && st.sleep_prev;
	// blanked compare; the S0 qualifier disables it in standby
	assign oc_trip  = (st.mode == APMS_S0) && pwm.blank_done
		&& syn[IX_OC_CMP];
	// a supply dropping away counts as the cycle that frees the latch
	assign supply_lost = |(st.good_prev & ~goods);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		next_st = st;
		next_st.sleep_prev = sleep;
		next_st.good_prev  = goods;
		next_st.std_mon    = ref_ok;
		next_st.sup_mon    = ref_ok && syn[IX_STANDBY] && st.std_mon;

		if (oc_trip)
			next_st.oc = 1'b1;
		else if (supply_lost || syn[IX_SS_GND] || !ref_ok)
			next_st.oc = 1'b0;

		if (!ref_ok)
			next_st.mode = APMS_S5;
		else
		begin
			case (st.mode)
				APMS_S5:
					if (all_good && !sleep && !st.oc)
						next_st.mode = APMS_S0;
				APMS_S0:
					if (st.oc || !all_good)
						next_st.mode = APMS_S5;
					else if (rise)
						next_st.mode = APMS_S3;
				APMS_S3:
					// gate and aux loss expected here, never leads to S5
					if (fall && goods[1] && goods[0])
						next_st.mode = APMS_S0;
				default:
					next_st.mode = APMS_S5;
			endcase
		end

		run = (next_st.mode != APMS_S5) && !next_st.oc;
		// soft-start stays on through S3 so S3 to S0 does not re-ramp
		next_st.ss_en  = run;
		next_st.in_reg = run && (next_st.mode == APMS_S0)
			&& syn[IX_SS_DONE] && syn[IX_RAIL_OK];
		next_st.hs = run && pwm.high_side;
		next_st.ls = run && !pwm.high_side;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops

	assign mode                    = st.mode;
	assign standby_monitor_en      = st.std_mon;
	assign supply_monitor_en       = st.sup_mon;
	assign soft_start_en           = st.ss_en;
	assign main_rail_in_regulation = st.in_reg;
	assign termination_en          = st.in_reg;
	assign termination_oe_n        = !st.in_reg;
	assign linear_oe_n             = !st.in_reg;
	assign first_linear_drive      = st.in_reg;
	assign second_linear_drive     = st.in_reg;
	assign high_side_gate          = st.hs;
	assign low_side_gate           = st.ls;
	assign overcurrent_latched     = st.oc;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_sleep_rise;
		st.mode == APMS_S0 && ref_ok && all_good && !st.oc && rise;
	endsequence

	sequence s_wake_fall;
		st.mode == APMS_S3 && ref_ok && fall && goods[1] && goods[0];
	endsequence

	sequence s_ramp_start;
		st.mode == APMS_S5 ##1 st.mode == APMS_S0;
	endsequence

	a_s3_not_s5: assert property (
		st.mode == APMS_S3 |=> st.mode != APMS_S5)
		else $error("S3 stepped to S5");
	a_s5_not_s3: assert property (
		st.mode == APMS_S5 |=> st.mode != APMS_S3)
		else $error("S5 stepped to S3");
	a_idle_no_ref: assert property (
		!ref_ok |=> st.mode == APMS_S5 && !st.hs && !st.ss_en)
		else $error("active without reference");
	a_enter_s0: assert property (
		(st.mode == APMS_S5 && ref_ok && all_good && !sleep && !st.oc)
		|=> st.mode == APMS_S0 && st.ss_en && !st.in_reg)
		else $error("missed S5 to S0");
	a_sleep_entry: assert property (s_sleep_rise |=> st.mode == APMS_S3)
		else $error("missed S0 to S3");
	a_s3_holds: assert property (
		(st.mode == APMS_S3 && ref_ok && !fall) |=> st.mode == APMS_S3)
		else $error("left S3 without falling sleep");
	a_wake_s0: assert property (
		s_wake_fall |=> st.mode == APMS_S0 ##1 (st.mode == APMS_S0
		|| !$past(ref_ok) || !$past(all_good) || $past(st.oc)
		|| $past(rise)))
		else $error("missed S3 to S0");
	a_supply_loss: assert property (
		(st.mode == APMS_S0 && ref_ok && !all_good) |=> st.mode == APMS_S5)
		else $error("S0 kept after supply loss");
	a_oc_latch: assert property (
		oc_trip |=> st.oc && !high_side_gate && !low_side_gate
		&& !first_linear_drive && !termination_en)
		else $error("overcurrent not latched off");
	a_oc_hold: assert property (
		(st.oc && !supply_lost && !syn[IX_SS_GND] && ref_ok)
		|=> st.oc && st.mode == APMS_S5 && !high_side_gate)
		else $error("latch released without cause");
	a_oc_off_s3: assert property (
		(st.mode == APMS_S3 && !st.oc) |=> !st.oc)
		else $error("overcurrent latched in S3");
	a_linear_s0: assert property (
		first_linear_drive |-> st.mode == APMS_S0 && !linear_oe_n)
		else $error("linear drive outside S0");

	// per-mode output levels and start-up order
	a_ramp_first: assert property (
		s_ramp_start |-> soft_start_en && !termination_en
		&& !first_linear_drive)
		else $error("S0 entry started more than the main ramp");
	a_gates_apart: assert property (
		!(high_side_gate && low_side_gate))
		else $error("both main gates on");
	a_s5_quiet: assert property (
		st.mode == APMS_S5 |-> !high_side_gate && !low_side_gate
		&& !first_linear_drive && !second_linear_drive
		&& termination_oe_n && linear_oe_n)
		else $error("S5 outputs not parked");
	a_s3_lin_off: assert property (
		st.mode == APMS_S3 |-> !termination_en && termination_oe_n
		&& linear_oe_n && !second_linear_drive)
		else $error("linear or termination on in S3");

	// monitor chain and regulation gating
	a_monitor_order: assert property (
		supply_monitor_en |-> standby_monitor_en)
		else $error("gate/aux monitor ahead of standby monitor");
	a_ref_monitor: assert property (
		!ref_ok |=> !standby_monitor_en && !supply_monitor_en)
		else $error("monitors on without reference");
	a_reg_needs_ss: assert property (
		main_rail_in_regulation
		|-> $past(syn[IX_SS_DONE]) && $past(syn[IX_RAIL_OK]))
		else $error("in-regulation before ramp done");

	// the latch only ever sets from a blanked compare
	a_oc_from_trip: assert property (
		$rose(st.oc) |-> $past(oc_trip))
		else $error("latch set without blanked compare");
endmodule // apms_seq

// file: test/apms_board.sv
// board-side model: chipset sleep request, supply detectors, soft-start
// assumes the sequencer samples every level on the rising edge of clk
`timescale 1ns/1ps
module apms_board #(
	parameter int RAMP = 12 // soft-start ramp length in cycles
) (
	input  wire logic clk,                  // system clock
	input  wire logic soft_start_en,        // main ramp allowed
	output logic      sleep_request,        // high asks S3
	output logic      standby_supply_good,  // standby detector
	output logic      gate_supply_good,     // gate detector
	output logic      aux_supply_good,      // aux detector
	output logic      reference_good,       // bandgap ok
	output logic      soft_start_done,      // ramp finished
	output logic      main_rail_regulating, // rail in window
	output logic      switch_below_sense,   // oc comparator
	output logic      soft_start_grounded   // ss pin pulled low
);
	int ramp_cnt;

	initial
	begin
		{sleep_request, standby_supply_good, gate_supply_good} = 3'h0;
		{aux_supply_good, reference_good, switch_below_sense} = 3'h0;
		soft_start_grounded = 1'b0;
		ramp_cnt = 0;
	end

	// the ramp restarts whenever the switcher is stopped or ss is grounded
	always @(posedge clk)
	begin
		if (!soft_start_en || soft_start_grounded)
			ramp_cnt <= 0;
		else if (ramp_cnt < RAMP)
			ramp_cnt <= ramp_cnt + 1;
	end
	assign soft_start_done      = (ramp_cnt == RAMP);
	assign main_rail_regulating = (ramp_cnt == RAMP);

	task levels(input logic r, s, g, a, sl);
		@(posedge clk);
		reference_good      <= r;
		standby_supply_good <= s;
		gate_supply_good    <= g;
		aux_supply_good     <= a;
		sleep_request       <= sl;
	endtask

	// a supply cycle, grounding ss or losing the reference are the only ways out of latch-off
	task fault(input logic oc, input logic gnd);
		@(posedge clk);
		switch_below_sense  <= oc;
		soft_start_grounded <= gnd;
	endtask
endmodule // apms_board

// file: test/apms_seq_tb_top.sv
// self-checking bench of the power mode sequencer
// assumes apms_board stands for the chipset and the supplies
`timescale 1ns/1ps
module apms_seq_tb_top;
	import apms_pkg::*;
	localparam int RAMP  = 12;
	localparam int LIMIT = 20000;
	logic clk, rst, hs, ls;
	logic [CNT_W-1:0] duty_cmd;
	logic sl, sg, gg, ag, rg, sd, rr, oc, sgnd;
	logic [1:0] mode;
	logic smon, gmon, ssen, inreg, ten, toe_n, loe_n, d1, d2, ocl;
	logic [7:0] per, hi, cmp;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;

	apms_board #(.RAMP(RAMP)) board (.clk(clk), .soft_start_en(ssen),
		.sleep_request(sl), .standby_supply_good(sg),
		.gate_supply_good(gg), .aux_supply_good(ag), .reference_good(rg),
		.soft_start_done(sd), .main_rail_regulating(rr),
		.switch_below_sense(oc), .soft_start_grounded(sgnd));

	apms_seq dut (.clk(clk), .rst(rst), .sleep_request(sl),
		.standby_supply_good(sg), .gate_supply_good(gg),
		.aux_supply_good(ag), .reference_good(rg), .soft_start_done(sd),
		.main_rail_regulating(rr), .switch_below_sense(oc),
		.soft_start_grounded(sgnd), .duty_cmd(duty_cmd), .mode(mode),
		.standby_monitor_en(smon), .supply_monitor_en(gmon),
		.soft_start_en(ssen), .main_rail_in_regulation(inreg),
		.termination_en(ten), .termination_oe_n(toe_n),
		.linear_oe_n(loe_n), .first_linear_drive(d1),
		.second_linear_drive(d2), .high_side_gate(hs),
		.low_side_gate(ls), .overcurrent_latched(ocl));

	always #20 clk = ~clk;

	////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_fail++;
			end_sim();
		end
	end

	task check(input string nm, input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// two edges through the synchroniser, one into the state, one spare
	task settle;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask

	task chk_mode(input apms_mode_t m);
		check("mode", {6'h00, mode}, 8'(m));
	endtask

	// off state: both gates and drives low, outputs released
	task chk_off;
		check("gates", {6'h00, hs, ls}, 8'h00);
		check("drives", {6'h00, d1, d2}, 8'h00);
		check("oe_n", {6'h00, toe_n, loe_n}, 8'h03);
	endtask

	// one full switching period, from falling edge to falling edge
	task measure;
		int n;
		logic up;
		n = 0;
		up = 1'b0;
		{per, hi, cmp} = 24'h0;
		while (hs !== 1'b1 && n < 300) begin @(negedge clk); n++; end
		while (hs === 1'b1 && n < 300) begin @(negedge clk); n++; end
		while (!(up && hs === 1'b0) && n < 600)
		begin
			if (hs === 1'b1) begin up = 1'b1; hi++; end
			if (ls === hs) cmp++;
			per++;
			@(negedge clk);
			n++;
		end
	endtask

	task wait_trip;
		int n;
		n = 0;
		while (ocl !== 1'b1 && n < 300) begin @(negedge clk); n++; end
		settle();
	endtask

	////////////////////////////////////////////////////////////////////
	task t_wake_up;
		@(negedge clk);
		chk_mode(APMS_S5);
		chk_off();
		board.levels(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		settle();
		chk_mode(APMS_S5);
		check("standby_mon", {7'h00, smon}, 8'h00);
	endtask

	task t_start;
		board.levels(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		settle();
		check("mon_en", {6'h00, smon, gmon}, 8'h02);
		board.levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		settle();
		check("mon_en", {6'h00, smon, gmon}, 8'h03);
		chk_mode(APMS_S5);
		board.levels(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		settle();
		chk_mode(APMS_S5);
		board.levels(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		settle();
		chk_mode(APMS_S0);
		check("ss_en_term", {6'h00, ssen, ten}, 8'h02);
		check("drives", {6'h00, d1, d2}, 8'h00);
		repeat (RAMP + 6) @(posedge clk);
		@(negedge clk);
		check("in_reg_term", {6'h00, inreg, ten}, 8'h03);
		check("drives", {6'h00, d1, d2}, 8'h03);
		check("oe_n", {6'h00, toe_n, loe_n}, 8'h00);
		measure();
		check("period_s0", per, 8'(PERIOD_S0));
		check("on_s0", hi, 8'h28);
		check("overlap", cmp, 8'h00);
	endtask

	task t_sleep;
		board.levels(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		settle();
		chk_mode(APMS_S3);
		check("in_reg_term", {6'h00, inreg, ten}, 8'h00);
		check("drives", {6'h00, d1, d2}, 8'h00);
		check("oe_n", {6'h00, toe_n, loe_n}, 8'h03);
		board.levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		settle();
		chk_mode(APMS_S3);
		measure();
		check("period_s3", per, 8'(PERIOD_S3));
		check("on_s3", hi, 8'h14);
		@(posedge clk);
		duty_cmd <= 7'h64;
		measure();
		measure();
		check("on_cap_s3", hi, 8'(DUTY_MAX_S3));
		board.fault(1'b1, 1'b0);
		repeat (120) @(posedge clk);
		@(negedge clk);
		check("oc_s3", {7'h00, ocl}, 8'h00);
		chk_mode(APMS_S3);
		board.fault(1'b0, 1'b0);
		board.levels(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		settle();
		chk_mode(APMS_S3);
		board.levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		settle();
		@(posedge clk);
		duty_cmd <= 7'h28;
	endtask

	task t_resume;
		board.levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		settle();
		chk_mode(APMS_S3);
		board.levels(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		settle();
		chk_mode(APMS_S3);
		board.levels(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		settle();
		board.levels(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		settle();
		chk_mode(APMS_S0);
		board.levels(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		settle();
		chk_mode(APMS_S5);
		chk_off();
		board.levels(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		settle();
		chk_mode(APMS_S0);
	endtask

	task t_overcurrent;
		@(posedge clk);
		duty_cmd <= 7'h05;
		board.fault(1'b1, 1'b0);
		repeat (300) @(posedge clk);
		@(negedge clk);
		check("oc_blank", {7'h00, ocl}, 8'h00);
		@(posedge clk);
		duty_cmd <= 7'h28;
		wait_trip();
		check("oc_latch", {7'h00, ocl}, 8'h01);
		chk_mode(APMS_S5);
		check("term_en", {7'h00, ten}, 8'h00);
		chk_off();
		board.fault(1'b0, 1'b0);
		settle();
		check("oc_hold", {6'h00, ocl, ssen}, 8'h02);
		board.fault(1'b0, 1'b1);
		settle();
		check("oc_clear_ss", {7'h00, ocl}, 8'h00);
		board.fault(1'b0, 1'b0);
		settle();
		chk_mode(APMS_S0);
		board.fault(1'b1, 1'b0);
		wait_trip();
		board.fault(1'b0, 1'b0);
		board.levels(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		settle();
		check("oc_clear_cyc", {7'h00, ocl}, 8'h00);
		board.levels(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
		settle();
		chk_mode(APMS_S0);
	endtask

	////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		duty_cmd = 7'h28;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_wake_up();
		t_start();
		t_sleep();
		t_resume();
		t_overcurrent();
		end_sim();
	end
endmodule // apms_seq_tb_top
